// ===== pefo_consts.svh
// Constants for the port E/F alternate-function override block.
// Assumes inclusion by bare name from the package and the design module.
`ifndef PEFO_CONSTS_SVH
`define PEFO_CONSTS_SVH
// ----------------------------------------------------------------
// Widths and bit positions
// ----------------------------------------------------------------
`define PEFO_PORT_W 8
`define PEFO_BIT_VBUS 7
`define PEFO_BIT_ID 3
`define PEFO_BIT_ALE 2
`define PEFO_BIT_RD 1
`define PEFO_BIT_WR 0
`define PEFO_BIT_TDI 7
`define PEFO_BIT_TDO 6
`define PEFO_BIT_TMS 5
`define PEFO_BIT_TCK 4
// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define PEFO_RST_BYTE 8'h00
`define PEFO_RST_BIT 1'b0
// ----------------------------------------------------------------
// Override values
// ----------------------------------------------------------------
`define PEFO_IRQ_GATE_VAL 4'hf
`define PEFO_MEM_DIR_VAL 3'h6
`define PEFO_SCAN_PU_VAL 4'hb
`define PEFO_ANALOG_ALL 8'hff
`endif

// ===== pefo_override.sv
// Port E and port F pin override logic with registered pad controls.
// Assumes pads, port registers and peripherals are synchronous to clk;
// the test access port state arrives already decoded from its own clock.
`timescale 1ns/10ps
`include "pefo_consts.svh"

// How it works
// - Vbus control forces PE7 output; interrupt enables force PE7..4 input gate on.
// - Id pin enable forces PE3 pull-up on, input direction, input kept enabled.
// - External memory enable drives PE2..1 with strobes, PE0 forced input; PE1/PE0 pull-ups off.
// - Scan port enabled: pull-ups on TDI, TMS, TCK held on even through reset.
// - Scan port enabled: PF7..4 leave port use, input gate forced off.
// - TDO drives only in instruction or data shift states, else high impedance.
// - Scan state arrives decoded; TDO and scan input registers run on the system clock.
// - PF3..0 have every override enable held at zero.
// - Each port F pin gives an analog path to the same-numbered converter channel.
module pefo_override
    import pefo_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire pefo_byte_t port_e_pullup,
    input wire pefo_byte_t port_e_dir,
    input wire pefo_byte_t port_e_out,
    input wire pefo_byte_t port_f_pullup,
    input wire pefo_byte_t port_f_dir,
    input wire pefo_byte_t port_f_out,
    input wire pefo_byte_t port_e_pin_in,
    input wire pefo_byte_t port_f_pin_in,
    input wire logic [3:0] ext_irq_en,
    input wire logic vbus_supply_ctrl_en,
    input wire logic vbus_supply_ctrl,
    input wire logic otg_id_pin_en,
    input wire logic ext_mem_iface_en,
    input wire logic ext_mem_addr_latch,
    input wire logic ext_mem_rd_strobe,
    input wire logic ext_mem_wr_strobe,
    input wire logic scan_port_en,
    input wire logic instr_shift_state,
    input wire logic data_shift_state,
    input wire logic scan_tdo,
    output logic [7:0] port_e_pad_pullup,
    output logic [7:0] port_e_pad_oe,
    output logic [7:0] port_e_pad_out,
    output logic [7:0] port_e_pin_input_signal,
    output logic [7:0] port_f_pad_pullup,
    output logic [7:0] port_f_pad_oe,
    output logic [7:0] port_f_pad_out,
    output logic [7:0] port_f_pin_input_signal,
    output logic ext_irq7_in,
    output logic ext_irq6_in,
    output logic ext_irq5_in,
    output logic ext_irq4_in,
    output logic otg_id_level,
    output logic boot_select_in,
    output logic scan_tdi_in,
    output logic scan_tms_in,
    output logic scan_tck_in,
    output logic [7:0] analog_path_sel
);

    // ------------------------------------------------------------
    // Override tables
    // ------------------------------------------------------------
    pefo_byte_t e_pu_en, e_pu_val, e_dd_en, e_dd_val;
    pefo_byte_t e_pv_en, e_pv_val, e_ig_en, e_ig_val;
    pefo_byte_t f_pu_en, f_pu_val, f_dd_en, f_dd_val;
    pefo_byte_t f_pv_en, f_pv_val, f_ig_en, f_ig_val;
    pefo_byte_t next_e_pu, next_e_oe, next_e_out, next_e_in;
    pefo_byte_t next_f_pu, next_f_oe, next_f_out, next_f_in;
    logic scan_shifting;
    pefo_byte_t next_f_pu_rst, next_analog;
    logic [3:0] next_irq_in;
    logic next_id_level, next_boot_in;
    logic next_tdi_in, next_tms_in, next_tck_in;

    always_comb begin
        e_pu_en = `PEFO_RST_BYTE;
        e_pu_val = `PEFO_RST_BYTE;
        e_dd_en = `PEFO_RST_BYTE;
        e_dd_val = `PEFO_RST_BYTE;
        e_pv_en = `PEFO_RST_BYTE;
        e_pv_val = `PEFO_RST_BYTE;
        e_ig_en = `PEFO_RST_BYTE;
        e_ig_val = `PEFO_RST_BYTE;
        // Port E bits 7..4
        e_dd_en[`PEFO_BIT_VBUS] = vbus_supply_ctrl_en;
        e_dd_val[`PEFO_BIT_VBUS] = vbus_supply_ctrl_en;
        e_pv_en[`PEFO_BIT_VBUS] = vbus_supply_ctrl_en;
        e_pv_val[`PEFO_BIT_VBUS] = vbus_supply_ctrl;
        e_ig_en[7:4] = ext_irq_en;
        e_ig_val[7:4] = `PEFO_IRQ_GATE_VAL;
        // Port E bit 3
        e_pu_en[`PEFO_BIT_ID] = otg_id_pin_en;
        e_pu_val[`PEFO_BIT_ID] = 1'b1;
        e_dd_en[`PEFO_BIT_ID] = otg_id_pin_en;
        e_dd_val[`PEFO_BIT_ID] = 1'b0;
        e_ig_en[`PEFO_BIT_ID] = otg_id_pin_en;
        e_ig_val[`PEFO_BIT_ID] = 1'b1;
        // Port E bits 2..0
        e_pu_en[`PEFO_BIT_RD] = ext_mem_iface_en;
        e_pu_en[`PEFO_BIT_WR] = ext_mem_iface_en;
        e_dd_en[2:0] = {3{ext_mem_iface_en}};
        e_dd_val[2:0] = `PEFO_MEM_DIR_VAL;
        e_pv_en[2:0] = {3{ext_mem_iface_en}};
        e_pv_val[2:0] = {ext_mem_addr_latch, ext_mem_rd_strobe, ext_mem_wr_strobe};
        e_ig_val[`PEFO_BIT_WR] = 1'b1;
    end

    assign scan_shifting = instr_shift_state | data_shift_state;

    // ------------------------------------------------------------
    // Port F override table
    // ------------------------------------------------------------
    always_comb begin
        // Port F bits 3..0 keep all enables at zero
        f_pu_en = `PEFO_RST_BYTE;
        f_pu_val = `PEFO_RST_BYTE;
        f_dd_en = `PEFO_RST_BYTE;
        f_dd_val = `PEFO_RST_BYTE;
        f_pv_en = `PEFO_RST_BYTE;
        f_pv_val = `PEFO_RST_BYTE;
        f_ig_en = `PEFO_RST_BYTE;
        f_ig_val = `PEFO_RST_BYTE;
        f_pu_en[7:4] = {4{scan_port_en}};
        f_pu_val[7:4] = `PEFO_SCAN_PU_VAL;
        f_dd_en[7:4] = {4{scan_port_en}};
        f_dd_val[`PEFO_BIT_TDO] = scan_shifting;
        f_pv_en[`PEFO_BIT_TDO] = scan_port_en;
        f_pv_val[`PEFO_BIT_TDO] = scan_tdo;
        f_ig_en[7:4] = {4{scan_port_en}};
    end

    // ------------------------------------------------------------
    // Override merge per bit
    // ------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < `PEFO_PORT_W; gi++) begin : g_bit
            // Input gate passes the pin unless an override closes it
            always_comb begin
                next_e_pu[gi] = e_pu_en[gi] ? e_pu_val[gi] : port_e_pullup[gi];
                next_e_oe[gi] = e_dd_en[gi] ? e_dd_val[gi] : port_e_dir[gi];
                next_e_out[gi] = e_pv_en[gi] ? e_pv_val[gi] : port_e_out[gi];
                next_e_in[gi] = port_e_pin_in[gi] & (e_ig_en[gi] ? e_ig_val[gi] : 1'b1);
                next_f_pu[gi] = f_pu_en[gi] ? f_pu_val[gi] : port_f_pullup[gi];
                next_f_oe[gi] = f_dd_en[gi] ? f_dd_val[gi] : port_f_dir[gi];
                next_f_out[gi] = f_pv_en[gi] ? f_pv_val[gi] : port_f_out[gi];
                next_f_in[gi] = port_f_pin_in[gi] & (f_ig_en[gi] ? f_ig_val[gi] : 1'b1);
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Side inputs and reset values
    // ------------------------------------------------------------
    always_comb begin
        // Scan pull-ups survive reset while the port is enabled
        next_f_pu_rst = `PEFO_RST_BYTE;
        next_f_pu_rst[7:4] = `PEFO_SCAN_PU_VAL & {4{scan_port_en}};
        next_irq_in = next_e_in[7:4];
        next_id_level = next_e_in[`PEFO_BIT_ID];
        next_boot_in = next_e_in[`PEFO_BIT_ALE];
        // Scan inputs take the raw pin level; the gate only blocks port use
        next_tdi_in = port_f_pin_in[`PEFO_BIT_TDI];
        next_tms_in = port_f_pin_in[`PEFO_BIT_TMS];
        next_tck_in = port_f_pin_in[`PEFO_BIT_TCK];
        // Analog path to channel of same index present on all pins outside reset
        next_analog = `PEFO_ANALOG_ALL;
    end

    // ------------------------------------------------------------
    // Pad control registers
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            port_e_pad_pullup <= `PEFO_RST_BYTE;
            port_e_pad_oe <= `PEFO_RST_BYTE;
            port_e_pad_out <= `PEFO_RST_BYTE;
            port_e_pin_input_signal <= `PEFO_RST_BYTE;
            port_f_pad_pullup <= next_f_pu_rst;
            port_f_pad_oe <= `PEFO_RST_BYTE;
            port_f_pad_out <= `PEFO_RST_BYTE;
            port_f_pin_input_signal <= `PEFO_RST_BYTE;
        end else begin
            port_e_pad_pullup <= next_e_pu;
            port_e_pad_oe <= next_e_oe;
            port_e_pad_out <= next_e_out;
            port_e_pin_input_signal <= next_e_in;
            port_f_pad_pullup <= next_f_pu;
            port_f_pad_oe <= next_f_oe;
            port_f_pad_out <= next_f_out;
            port_f_pin_input_signal <= next_f_in;
        end
    end

    // ------------------------------------------------------------
    // Peripheral input registers
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ext_irq7_in <= `PEFO_RST_BIT;
            ext_irq6_in <= `PEFO_RST_BIT;
            ext_irq5_in <= `PEFO_RST_BIT;
            ext_irq4_in <= `PEFO_RST_BIT;
            otg_id_level <= `PEFO_RST_BIT;
            boot_select_in <= `PEFO_RST_BIT;
            scan_tdi_in <= `PEFO_RST_BIT;
            scan_tms_in <= `PEFO_RST_BIT;
            scan_tck_in <= `PEFO_RST_BIT;
            analog_path_sel <= `PEFO_RST_BYTE;
        end else begin
            ext_irq7_in <= next_irq_in[3];
            ext_irq6_in <= next_irq_in[2];
            ext_irq5_in <= next_irq_in[1];
            ext_irq4_in <= next_irq_in[0];
            otg_id_level <= next_id_level;
            boot_select_in <= next_boot_in;
            scan_tdi_in <= next_tdi_in;
            scan_tms_in <= next_tms_in;
            scan_tck_in <= next_tck_in;
            analog_path_sel <= next_analog;
        end
    end

endmodule : pefo_override

// ===== pefo_override_asserts.sv
// Assertions on the registered pad controls of the override block.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/10ps
module pefo_override_asserts
    import pefo_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic vbus_supply_ctrl_en,
    input wire logic vbus_supply_ctrl,
    input wire logic otg_id_pin_en,
    input wire logic ext_mem_iface_en,
    input wire logic ext_mem_wr_strobe,
    input wire logic scan_port_en,
    input wire logic scan_tdo,
    input wire logic instr_shift_state,
    input wire logic data_shift_state,
    input wire pefo_byte_t port_f_dir,
    input wire logic [7:0] port_e_pad_pullup,
    input wire logic [7:0] port_e_pad_oe,
    input wire logic [7:0] port_e_pad_out,
    input wire logic [7:0] port_f_pad_pullup,
    input wire logic [7:0] port_f_pad_oe,
    input wire logic [7:0] port_f_pad_out,
    input wire logic [7:0] port_f_pin_input_signal,
    input wire logic [7:0] analog_path_sel
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    sequence s_shift;
        scan_port_en && (instr_shift_state || data_shift_state);
    endsequence
    sequence s_idle;
        scan_port_en && !instr_shift_state && !data_shift_state;
    endsequence
    chk_vbus_force: assert property (vbus_supply_ctrl_en |=> port_e_pad_oe[7]
        && port_e_pad_out[7] == $past(vbus_supply_ctrl)) else $error("vbus pin not forced");
    chk_id_force: assert property (otg_id_pin_en |=> port_e_pad_pullup[3]
        && !port_e_pad_oe[3]) else $error("id pin not forced");
    chk_mem_strobes: assert property (ext_mem_iface_en |=> port_e_pad_out[0]
        == $past(ext_mem_wr_strobe) && {port_e_pad_oe[2:0], port_e_pad_pullup[1:0]} == 5'h18)
        else $error("strobe pins wrong");
    chk_scan_pullup: assert property (disable iff (1'b0) scan_port_en |=>
        port_f_pad_pullup[7:4] == 4'hb) else $error("scan pull-ups lost");
    chk_scan_pins: assert property (scan_port_en |=> port_f_pin_input_signal[7:4] == 4'h0
        && {port_f_pad_oe[7], port_f_pad_oe[5:4]} == 3'h0) else $error("scan pins not taken");
    chk_tdo_drive: assert property (s_shift |=> port_f_pad_oe[6]
        && port_f_pad_out[6] == $past(scan_tdo)) else $error("tdo not driven");
    chk_tdo_float: assert property (s_idle |=> !port_f_pad_oe[6])
        else $error("tdo driven outside shift");
    chk_low_plain: assert property (1'b1 |=> port_f_pad_oe[3:0] == $past(port_f_dir[3:0]))
        else $error("low port f overridden");
    chk_analog_path: assert property (1'b1 |=> analog_path_sel == 8'hff)
        else $error("analog path missing");
endmodule : pefo_override_asserts
bind pefo_override pefo_override_asserts i_chk (.*);

// ===== pefo_pads.sv
// Board model: resolves each pin level from its pad controls.
// Assumes registered pad controls; ext is the level the board applies.
`timescale 1ns/10ps
module pefo_pads
    import pefo_pkg::*;
(
    input wire pefo_byte_t pu,
    input wire pefo_byte_t oe,
    input wire pefo_byte_t out,
    input wire pefo_byte_t ext,
    output pefo_byte_t pin
);
    // Driven pins show the pad value, released pins the pull-up or board level
    always_comb pin = (oe & out) | (~oe & (pu | ext));
endmodule : pefo_pads

// ===== pefo_pkg.sv
// Types for the port E/F alternate-function override block.
// Assumes pefo_consts.svh is on the include path.
`include "pefo_consts.svh"
package pefo_pkg;
    typedef logic [`PEFO_PORT_W-1:0] pefo_byte_t;
endpackage : pefo_pkg

// ===== test_port_ef_alt_function_override.sv
// Directed testbench of the port E/F override block.
// Assumes pefo_pads as board model and the bound checker.
`timescale 1ns/10ps
module test_port_ef_alt_function_override;
    import pefo_pkg::*;
    logic clk, sys_rst, vbus_supply_ctrl_en, vbus_supply_ctrl, otg_id_pin_en, ext_mem_iface_en;
    logic ext_mem_addr_latch, ext_mem_rd_strobe, ext_mem_wr_strobe, scan_port_en, scan_tdo;
    logic instr_shift_state, data_shift_state, ext_irq7_in, ext_irq6_in, ext_irq5_in;
    logic ext_irq4_in, otg_id_level, boot_select_in, scan_tdi_in, scan_tms_in, scan_tck_in;
    logic [3:0] ext_irq_en;
    pefo_byte_t port_e_pullup, port_e_dir, port_e_out, port_f_pullup, port_f_dir, port_f_out;
    pefo_byte_t port_e_pin_in, port_f_pin_in, e_ext, f_ext;
    logic [7:0] port_e_pad_pullup, port_e_pad_oe, port_e_pad_out, port_e_pin_input_signal;
    logic [7:0] port_f_pad_pullup, port_f_pad_oe, port_f_pad_out, port_f_pin_input_signal;
    logic [7:0] analog_path_sel;
    int num_errors, checks_done, cycles;
    pefo_override i_dut (.*);
    pefo_pads i_pad_e (.pu(port_e_pad_pullup), .oe(port_e_pad_oe), .out(port_e_pad_out),
        .ext(e_ext), .pin(port_e_pin_in));
    pefo_pads i_pad_f (.pu(port_f_pad_pullup), .oe(port_f_pad_oe), .out(port_f_pad_out),
        .ext(f_ext), .pin(port_f_pin_in));
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask : cmp
    task automatic settle();
        repeat (3) @(posedge clk);
        #1;
    endtask : settle
    task automatic results();
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : results
    task automatic t_plain();
        {port_e_dir, port_e_pullup, port_e_out, port_f_dir, port_f_pullup} = 40'h5a_0f33_0fa0;
        settle();
        cmp(port_e_pad_oe, 8'h5a);
        cmp(port_e_pin_input_signal, 8'h17);
        cmp(port_f_pin_input_signal, 8'ha0);
        cmp({boot_select_in, scan_tdi_in, scan_tms_in, scan_tck_in, 4'h0}, 8'he0);
        cmp(analog_path_sel, 8'hff);
        $display("test plain done");
    endtask : t_plain
    task automatic t_vbus();
        {vbus_supply_ctrl_en, vbus_supply_ctrl, ext_irq_en} = 6'h3f;
        {port_e_dir, port_e_pullup, port_e_out, e_ext} = 32'h0000_0050;
        settle();
        cmp(port_e_pad_oe & port_e_pad_out, 8'h80);
        cmp({ext_irq7_in, ext_irq6_in, ext_irq5_in, ext_irq4_in, 4'h0}, 8'hd0);
        $display("test vbus done");
    endtask : t_vbus
    task automatic t_id();
        {vbus_supply_ctrl_en, otg_id_pin_en, port_e_dir, e_ext} = 18'h1_0800;
        settle();
        cmp({port_e_pad_pullup[3], port_e_pad_oe[3], otg_id_level, 5'h0}, 8'ha0);
        $display("test id done");
    endtask : t_id
    task automatic t_mem();
        {otg_id_pin_en, ext_mem_iface_en, ext_mem_addr_latch, ext_mem_rd_strobe} = 4'h6;
        {ext_mem_wr_strobe, port_e_dir, port_e_pullup} = 17'h1_0103;
        settle();
        cmp({port_e_pad_oe[2:0], port_e_pad_out[2:0], port_e_pad_pullup[1:0]}, 8'hd4);
        $display("test mem done");
    endtask : t_mem
    task automatic t_scan();
        {ext_mem_iface_en, scan_port_en} = 2'h1;
        // Port F outputs stay still while checked
        {port_f_dir, port_f_pullup, port_f_out, f_ext} = 32'hff00_0f00;
        for (int i = 0; i < 3; i++) begin
            {instr_shift_state, data_shift_state, scan_tdo} = {i[1:0], i[0]};
            settle();
            cmp(port_f_pad_oe, {1'b0, i != 0, 6'h0f});
            cmp(port_f_pad_out, {1'b0, i[0], 6'h0f});
            cmp(port_f_pin_input_signal, 8'h0f);
        end
        sys_rst = 1'b1;
        settle();
        cmp(port_f_pad_pullup, 8'hb0);
        sys_rst = 1'b0;
        settle();
        cmp(port_f_pad_oe, 8'h4f);
        $display("test scan done");
    endtask : t_scan
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 400) begin
            num_errors++;
            results();
        end
    end
    initial begin
        {num_errors, checks_done, cycles} = '0;
        {sys_rst, scan_port_en, vbus_supply_ctrl_en, vbus_supply_ctrl, otg_id_pin_en} = 5'h18;
        {ext_mem_iface_en, ext_mem_addr_latch, ext_mem_rd_strobe, ext_mem_wr_strobe} = '0;
        {instr_shift_state, data_shift_state, scan_tdo, ext_irq_en, e_ext, f_ext} = '0;
        {port_e_pullup, port_e_dir, port_e_out, port_f_pullup, port_f_dir, port_f_out} = '0;
        repeat (6) @(posedge clk);
        #1;
        cmp(port_f_pad_pullup, 8'hb0);
        {sys_rst, scan_port_en} = 2'h0;
        t_plain();
        t_vbus();
        t_id();
        t_mem();
        t_scan();
        results();
    end
endmodule : test_port_ef_alt_function_override
